// >>> pkg/dcb_pkg.sv
// drive comm control/status bank: parameter numbers, field positions, codes
// assumes: compiled before every rtl file of the bank
package dcb_pkg;

    // parameter numbers, used as register indices
    typedef logic [9:0] dcb_pnum_t;
    localparam dcb_pnum_t PNUM_STATUS_TWO = 10'h2b2; // 690
    localparam dcb_pnum_t PNUM_ERR_ACTION = 10'h139; // 313
    localparam dcb_pnum_t PNUM_CW_SERIAL = 10'h2aa; // 682
    localparam dcb_pnum_t PNUM_REF_SERIAL = 10'h2ab; // 683
    localparam dcb_pnum_t PNUM_CW_FBUS = 10'h2ac; // 684
    localparam dcb_pnum_t PNUM_REF_FBUS = 10'h2ad; // 685
    localparam dcb_pnum_t PNUM_SER_ADDR = 10'h134; // 308
    localparam dcb_pnum_t PNUM_SER_BAUD = 10'h136; // 310
    localparam dcb_pnum_t PNUM_SER_FMT = 10'h137; // 311
    localparam dcb_pnum_t PNUM_SER_PROTO = 10'h138; // 312

    // requesting source of an access
    typedef enum logic [1:0] {
        SRC_SERIAL = 2'h0,
        SRC_FIELDBUS = 2'h1,
        SRC_OTHER = 2'h2
    } dcb_src_e;

    // control word field positions
    localparam int CW_RAMP_EN = 0;
    localparam int CW_GEN_EN = 1;
    localparam int CW_RUN_FWD = 2;
    localparam int CW_JOG_EN = 3;
    localparam int CW_REMOTE = 4;
    localparam int CW_RAMP2 = 5;
    localparam int CW_FAULT_RST = 7;
    localparam logic [15:0] CW_STORED_MASK = 16'h003f;

    // status word two field positions
    localparam int ST_DCLINK_EXT = 2;
    localparam int ST_ENERGY_SAVE = 3;
    localparam int ST_FREQ_REDUCE = 4;
    localparam int ST_DECEL = 6;
    localparam int ST_ACCEL = 7;
    localparam int ST_FROZEN = 8;
    localparam int ST_SETPOINT_OK = 9;
    localparam int ST_DCLINK_REG = 10;
    localparam int ST_CFG_50HZ = 11;
    localparam int ST_RIDE_THRU = 12;
    localparam int ST_FLY_START = 13;
    localparam int ST_DC_BRAKE = 14;
    localparam int ST_PWM_ON = 15;

    // reset values
    localparam logic [15:0] RST_CW = 16'h0000;
    localparam logic [15:0] RST_REF = 16'h0000;
    localparam logic [7:0] RST_ADDR = 8'h01;
    localparam logic [2:0] RST_BAUD = 3'h0;
    localparam logic [2:0] RST_FMT = 3'h1;
    localparam logic [2:0] RST_PROTO = 3'h2;

    // legal ranges and codes
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'hf7;
    localparam logic [2:0] BAUD_MAX = 3'h4;
    localparam logic [2:0] FMT_MAX = 3'h5;
    localparam logic [2:0] FMT_TWO_STOP_FIRST = 3'h3;
    localparam logic [2:0] PROTO_SLAVE = 3'h2;
    localparam logic [2:0] PROTO_BACNET = 3'h3;
    localparam logic [2:0] PROTO_MASTER = 3'h5;
    localparam logic [7:0] DEF_LOAD_60HZ = 8'h05;
    localparam logic [7:0] DEF_LOAD_50HZ = 8'h06;
    localparam logic signed [15:0] SPEED_RATED = 16'sh2000;

    // action on communication error
    typedef enum logic [2:0] {
        EA_NONE = 3'h0,
        EA_RAMP_STOP = 3'h1,
        EA_DISABLE = 3'h2,
        EA_LOCAL = 3'h3,
        EA_LOCAL_KEEP = 3'h4,
        EA_FAULT = 3'h5
    } dcb_erract_e;

    // bit rate in bits per second for a rate code
    function automatic logic [16:0] dcb_bit_rate(input logic [2:0] code);
        unique case (code)
            3'h0: dcb_bit_rate = 17'd9600;
            3'h1: dcb_bit_rate = 17'd19200;
            3'h2: dcb_bit_rate = 17'd38400;
            3'h3: dcb_bit_rate = 17'd57600;
            default: dcb_bit_rate = 17'd76800;
        endcase
    endfunction : dcb_bit_rate

endpackage : dcb_pkg

// >>> rtl/dcb_cmd_apply.sv
// drive comm bank: applies the active control word to the drive
// assumes: inputs synchronous to clock_i, error reaction decided by the bank
`timescale 1ns/100ps
module dcb_cmd_apply (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // from the bank
    input wire logic [15:0] cw_i,
    input wire logic tripped_i,
    input wire dcb_pkg::dcb_erract_e action_i,
    input wire logic fault_clear_i,
    // drive commands
    output logic ramp_enable_o,
    output logic general_enable_o,
    output logic run_forward_o,
    output logic jog_enable_o,
    output logic remote_o,
    output logic second_ramp_o,
    output logic fault_reset_o
);
    import dcb_pkg::*;

    typedef struct packed {
        logic [5:0] cmd;
        logic fault_reset;
    } dcb_apply_s;

    dcb_apply_s state_reg;
    dcb_apply_s state_next;

    // error reaction overrides the written bits only while tripped
    always_comb begin
        state_next = state_reg;
        state_next.cmd = cw_i[5:0];
        state_next.fault_reset = fault_clear_i;
        if (tripped_i) begin
            unique case (action_i)
                EA_RAMP_STOP: state_next.cmd[CW_RAMP_EN] = 1'b0;
                EA_DISABLE: state_next.cmd[CW_GEN_EN] = 1'b0;
                EA_LOCAL: begin
                    state_next.cmd[CW_REMOTE] = 1'b0;
                    state_next.cmd[CW_GEN_EN] = 1'b0;
                end
                EA_LOCAL_KEEP: state_next.cmd[CW_REMOTE] = 1'b0;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // each bit drives one drive function
    assign ramp_enable_o = state_reg.cmd[CW_RAMP_EN];
    assign general_enable_o = state_reg.cmd[CW_GEN_EN];
    assign run_forward_o = state_reg.cmd[CW_RUN_FWD];
    assign jog_enable_o = state_reg.cmd[CW_JOG_EN];
    assign remote_o = state_reg.cmd[CW_REMOTE];
    assign second_ramp_o = state_reg.cmd[CW_RAMP2];
    assign fault_reset_o = state_reg.fault_reset;

endmodule : dcb_cmd_apply

// >>> rtl/dcb_bank.sv
// drive comm control/status bank: parameter access port, status word two,
// control words, speed references, comm error action and serial settings
// assumes: one access port shared by all sources, status flags from the drive
// core, all inputs synchronous to clock_i
`timescale 1ns/100ps
module dcb_bank (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // parameter access port
    input wire logic req_i,
    input wire logic we_i,
    input wire dcb_pkg::dcb_src_e src_i,
    input wire dcb_pkg::dcb_pnum_t pnum_i,
    input wire logic [15:0] wdata_i,
    output logic ack_o,
    output logic refused_o,
    output logic [15:0] rdata_o,
    // drive core status flags
    input wire logic dclink_ext_i,
    input wire logic energy_save_i,
    input wire logic output_frequency_reduction_i,
    input wire logic decel_ramp_i,
    input wire logic accel_ramp_i,
    input wire logic ramp_frozen_i,
    input wire logic setpoint_ok_i,
    input wire logic dclink_reg_i,
    input wire logic defaults_load_i,
    input wire logic [7:0] defaults_load_code_i,
    input wire logic ride_through_i,
    input wire logic flying_start_i,
    input wire logic dc_brake_i,
    input wire logic pwm_enabled_i,
    input wire logic fault_i,
    // reference selection and comm error
    input wire logic fieldbus_active_i,
    input wire logic ref_from_network_i,
    input wire logic comm_error_i,
    // drive commands
    output logic ramp_enable_o,
    output logic general_enable_o,
    output logic run_forward_o,
    output logic jog_enable_o,
    output logic remote_o,
    output logic second_ramp_o,
    output logic fault_reset_o,
    output logic fault_raise_o,
    output logic comm_tripped_o,
    // speed reference to the ramp
    output logic signed [15:0] speed_ref_o,
    output logic speed_ref_valid_o,
    // serial port settings
    output logic [7:0] serial_slave_address_o,
    output logic [16:0] serial_bit_rate_o,
    output logic [1:0] serial_parity_o,
    output logic serial_two_stop_o,
    output logic [2:0] serial_protocol_o
);
    import dcb_pkg::*;

    // comm error reaction states
    typedef enum logic [1:0] {
        CE_NORMAL = 2'b01,
        CE_TRIPPED = 2'b10
    } dcb_cerr_e;

    typedef struct packed {
        logic [15:0] cw_serial;
        logic [15:0] cw_fbus;
        logic [15:0] ref_serial;
        logic [15:0] ref_fbus;
        logic [7:0] addr;
        logic [2:0] baud;
        logic [2:0] fmt;
        logic [2:0] proto;
        dcb_erract_e err_act;
        logic cfg_50hz;
        logic [15:0] status;
        logic [15:0] rdata;
        logic ack;
        logic refused;
        logic fault_clear;
        logic fault_raise;
        logic signed [15:0] speed_ref;
        logic speed_valid;
        dcb_cerr_e cerr;
    } dcb_bank_s;

    dcb_bank_s state_reg;
    dcb_bank_s state_next;

    logic wr;
    logic cw_write;
    logic [15:0] cw_written;
    logic [15:0] cw_active;

    // a write is a request with we_i set
    assign wr = req_i && we_i;

    // combinational next state
    always_comb begin
        state_next = state_reg;
        cw_write = 1'b0;
        cw_written = '0;
        state_next.ack = req_i;
        state_next.refused = 1'b0;
        state_next.fault_raise = 1'b0;

        // status word two sampled every cycle
        state_next.status = '0;
        state_next.status[ST_DCLINK_EXT] = dclink_ext_i;
        state_next.status[ST_ENERGY_SAVE] = energy_save_i;
        state_next.status[ST_FREQ_REDUCE] = output_frequency_reduction_i;
        state_next.status[ST_DECEL] = decel_ramp_i;
        state_next.status[ST_ACCEL] = accel_ramp_i;
        state_next.status[ST_FROZEN] = ramp_frozen_i;
        state_next.status[ST_SETPOINT_OK] = setpoint_ok_i;
        state_next.status[ST_DCLINK_REG] = dclink_reg_i;
        state_next.status[ST_CFG_50HZ] = state_reg.cfg_50hz;
        state_next.status[ST_RIDE_THRU] = ride_through_i;
        state_next.status[ST_FLY_START] = flying_start_i;
        state_next.status[ST_DC_BRAKE] = dc_brake_i;
        state_next.status[ST_PWM_ON] = pwm_enabled_i;

        // defaults load only changes the flag for the two frequency codes
        if (defaults_load_i && defaults_load_code_i == DEF_LOAD_50HZ) begin
            state_next.cfg_50hz = 1'b1;
        end else if (defaults_load_i && defaults_load_code_i == DEF_LOAD_60HZ) begin
            state_next.cfg_50hz = 1'b0;
        end

        // read path: stored values keep reserved bits at zero
        if (req_i) begin
            unique case (pnum_i)
                PNUM_STATUS_TWO: state_next.rdata = state_reg.status;
                PNUM_ERR_ACTION: state_next.rdata = {13'h0000, state_reg.err_act};
                PNUM_CW_SERIAL: state_next.rdata = state_reg.cw_serial;
                PNUM_REF_SERIAL: state_next.rdata = state_reg.ref_serial;
                PNUM_CW_FBUS: state_next.rdata = state_reg.cw_fbus;
                PNUM_REF_FBUS: state_next.rdata = state_reg.ref_fbus;
                PNUM_SER_ADDR: state_next.rdata = {8'h00, state_reg.addr};
                PNUM_SER_BAUD: state_next.rdata = {13'h0000, state_reg.baud};
                PNUM_SER_FMT: state_next.rdata = {13'h0000, state_reg.fmt};
                PNUM_SER_PROTO: state_next.rdata = {13'h0000, state_reg.proto};
                default: begin
                    state_next.rdata = '0;
                    state_next.refused = 1'b1;
                end
            endcase
        end

        // write path: control words and references check the source, error action and serial settings check the legal range
        if (wr) begin
            unique case (pnum_i)
                PNUM_STATUS_TWO: state_next.refused = 1'b1;
                PNUM_ERR_ACTION: begin
                    if (wdata_i <= 16'(EA_FAULT)) begin
                        state_next.err_act = dcb_erract_e'(wdata_i[2:0]);
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_CW_SERIAL: begin
                    if (src_i == SRC_SERIAL) begin
                        state_next.cw_serial = wdata_i & CW_STORED_MASK;
                        cw_write = !fieldbus_active_i;
                        cw_written = wdata_i;
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_CW_FBUS: begin
                    if (src_i == SRC_FIELDBUS) begin
                        state_next.cw_fbus = wdata_i & CW_STORED_MASK;
                        cw_write = fieldbus_active_i;
                        cw_written = wdata_i;
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_REF_SERIAL: begin
                    if (src_i == SRC_SERIAL) begin
                        state_next.ref_serial = wdata_i;
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_REF_FBUS: begin
                    if (src_i == SRC_FIELDBUS) begin
                        state_next.ref_fbus = wdata_i;
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_SER_ADDR: begin
                    if (wdata_i >= 16'(ADDR_MIN) && wdata_i <= 16'(ADDR_MAX)) begin
                        state_next.addr = wdata_i[7:0];
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_SER_BAUD: begin
                    if (wdata_i <= 16'(BAUD_MAX)) begin
                        state_next.baud = wdata_i[2:0];
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_SER_FMT: begin
                    if (wdata_i <= 16'(FMT_MAX)) begin
                        state_next.fmt = wdata_i[2:0];
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                PNUM_SER_PROTO: begin
                    if (wdata_i == 16'(PROTO_SLAVE) || wdata_i == 16'(PROTO_BACNET)
                        || wdata_i == 16'(PROTO_MASTER)) begin
                        state_next.proto = wdata_i[2:0];
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                default: state_next.refused = 1'b1;
            endcase
        end

        // fault reset acts only on a registered fault
        state_next.fault_clear = cw_write && cw_written[CW_FAULT_RST] && fault_i;

        // comm error reaction holds until the master writes a fresh control word;
        // an error in the same cycle as that write wins, so no event is lost
        unique case (state_reg.cerr)
            CE_NORMAL: begin
                if (comm_error_i && state_reg.err_act != EA_NONE) begin
                    state_next.cerr = CE_TRIPPED;
                    state_next.fault_raise = (state_reg.err_act == EA_FAULT);
                end
            end
            CE_TRIPPED: begin
                if (cw_write && !comm_error_i) begin
                    state_next.cerr = CE_NORMAL;
                end
            end
            default: state_next.cerr = CE_NORMAL;
        endcase

        // speed reference reaches the ramp only when sourced from the network
        state_next.speed_valid = ref_from_network_i;
        if (ref_from_network_i) begin
            state_next.speed_ref = fieldbus_active_i ? signed'(state_reg.ref_fbus)
                                                     : signed'(state_reg.ref_serial);
        end else begin
            state_next.speed_ref = '0;
        end
    end

    // one register stage for the bank state; the drive command outputs take a second one in dcb_cmd_apply
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.cw_serial <= RST_CW;
            state_reg.cw_fbus <= RST_CW;
            state_reg.ref_serial <= RST_REF;
            state_reg.ref_fbus <= RST_REF;
            state_reg.addr <= RST_ADDR;
            state_reg.baud <= RST_BAUD;
            state_reg.fmt <= RST_FMT;
            state_reg.proto <= RST_PROTO;
            state_reg.err_act <= EA_NONE;
            state_reg.cerr <= CE_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // control word of the group owning the drive
    assign cw_active = fieldbus_active_i ? state_reg.cw_fbus : state_reg.cw_serial;

    // control word with the error reaction on top
    dcb_cmd_apply u_apply (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .cw_i(cw_active),
        .tripped_i(state_reg.cerr == CE_TRIPPED),
        .action_i(state_reg.err_act),
        .fault_clear_i(state_reg.fault_clear),
        .ramp_enable_o(ramp_enable_o),
        .general_enable_o(general_enable_o),
        .run_forward_o(run_forward_o),
        .jog_enable_o(jog_enable_o),
        .remote_o(remote_o),
        .second_ramp_o(second_ramp_o),
        .fault_reset_o(fault_reset_o)
    );

    // access answers
    assign ack_o = state_reg.ack;
    assign refused_o = state_reg.refused;
    assign rdata_o = state_reg.rdata;

    // error reaction outputs
    assign fault_raise_o = state_reg.fault_raise;
    assign comm_tripped_o = (state_reg.cerr == CE_TRIPPED);

    // speed reference
    assign speed_ref_o = state_reg.speed_ref;
    assign speed_ref_valid_o = state_reg.speed_valid;

    // serial settings decoded from stored codes
    assign serial_slave_address_o = state_reg.addr;
    assign serial_bit_rate_o = dcb_bit_rate(state_reg.baud);
    assign serial_parity_o = (state_reg.fmt >= FMT_TWO_STOP_FIRST) ?
                             2'(state_reg.fmt - FMT_TWO_STOP_FIRST) : state_reg.fmt[1:0];
    assign serial_two_stop_o = (state_reg.fmt >= FMT_TWO_STOP_FIRST);
    assign serial_protocol_o = state_reg.proto;

endmodule : dcb_bank

// >>> testbench/dcb_host_model.sv
// host model: network master making one-word accesses
// assumes: answer comes one edge after the request edge
`timescale 1ns/100ps
module dcb_host_model (
    // clock
    input wire logic clock_i,
    // request side
    output logic req_o, we_o,
    output dcb_pkg::dcb_src_e src_o,
    output dcb_pkg::dcb_pnum_t pnum_o,
    output logic [15:0] wdata_o,
    // answer side
    input wire logic ack_i, refused_i,
    input wire logic [15:0] rdata_i
);
    import dcb_pkg::*;
    // idle port at time zero
    initial begin
        req_o = 0; we_o = 0; src_o = SRC_OTHER; pnum_o = '0; wdata_o = '0;
    end
    // one-cycle request; answer read just after the taking edge
    task automatic access(input dcb_src_e s, input dcb_pnum_t p, input logic w, input logic [15:0] d,
        output logic a, r, output logic [15:0] q);
        @(posedge clock_i);
        req_o <= 1; we_o <= w; src_o <= s; pnum_o <= p; wdata_o <= d;
        @(posedge clock_i);
        req_o <= 0; wdata_o <= ~d;
        #1 a = ack_i; r = refused_i; q = rdata_i;
    endtask : access
endmodule : dcb_host_model

// >>> testbench/dcb_bank_monitor.sv
// checker on the bank's access port, reference and fault outputs
// assumes: bound to dcb_bank, one clock, reset active high
`timescale 1ns/100ps
module dcb_bank_monitor
    import dcb_pkg::*;
(
    input wire logic clock_i, rst_i, req_i, we_i, ack_o, refused_o,
    input wire dcb_pkg::dcb_src_e src_i,
    input wire dcb_pkg::dcb_pnum_t pnum_i,
    input wire logic [15:0] wdata_i, rdata_o,
    input wire logic ref_from_network_i, comm_error_i, fault_i, fault_raise_o, fault_reset_o,
    input wire logic signed [15:0] speed_ref_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic wr;
    assign wr = req_i && we_i;
    a_ack_latency: assert property (req_i |=> ack_o) else $error("no answer");
    a_ack_only_req: assert property (!req_i |=> !ack_o && !refused_o) else $error("stray answer");
    a_status_ro: assert property (wr && pnum_i == PNUM_STATUS_TWO |=> refused_o) else $error("status written");
    a_cw_owner: assert property (wr && pnum_i == PNUM_CW_SERIAL && src_i != SRC_SERIAL |=> refused_o)
        else $error("foreign cw taken");
    a_ref_owner: assert property (wr && pnum_i == PNUM_REF_FBUS && src_i != SRC_FIELDBUS |=> refused_o)
        else $error("foreign ref taken");
    a_addr_range: assert property (wr && pnum_i == PNUM_SER_ADDR && (wdata_i == 0 || wdata_i > 16'h00f7)
        |=> refused_o) else $error("bad address taken");
    a_status_rsv: assert property (ack_o && $past(pnum_i) == PNUM_STATUS_TWO |-> rdata_o[1:0] == 2'h0 && !rdata_o[5])
        else $error("status rsv bit set");
    a_cw_rsv: assert property (ack_o && $past(pnum_i) == PNUM_CW_SERIAL |-> rdata_o[15:6] == 10'h000)
        else $error("cw rsv bit set");
    a_ref_gate: assert property (!ref_from_network_i |=> speed_ref_o == 16'sh0000) else $error("ref not gated");
    a_raise_cause: assert property (fault_raise_o |-> $past(comm_error_i)) else $error("fault without error");
    a_reset_fault: assert property (fault_reset_o |-> $past(fault_i, 2)) else $error("reset without fault");
endmodule : dcb_bank_monitor
bind dcb_bank dcb_bank_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i),
    .ack_o(ack_o), .refused_o(refused_o), .src_i(src_i), .pnum_i(pnum_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .ref_from_network_i(ref_from_network_i), .comm_error_i(comm_error_i),
    .fault_raise_o(fault_raise_o), .fault_reset_o(fault_reset_o), .fault_i(fault_i), .speed_ref_o(speed_ref_o));

// >>> testbench/drive_comm_control_status_bank_tb.sv
// testbench for dcb_bank: host model accesses against rule values
// assumes: dcb_pkg compiled first, monitor bound
`timescale 1ns/100ps
module drive_comm_control_status_bank_tb;
    import dcb_pkg::*;
    logic clock_i, rst_i, req, we, ack, refd, dl, fault, fba, net, cerr, a, r;
    logic ramp_en, gen_en, fwd, jog, rem, ramp2, frst, fraise, trip, valid, two_stop;
    dcb_src_e src;
    dcb_pnum_t pnum;
    logic [15:0] wdata, rdata, q;
    logic [11:0] fl, st;
    logic [7:0] dlc, addr;
    logic signed [15:0] sref;
    logic [16:0] rate;
    logic [1:0] par;
    logic [2:0] proto;
    int mismatches, samples_checked, n_frst, n_raise, n0;
    int rt[5] = '{9600, 19200, 38400, 57600, 76800};
    dcb_pnum_t tp[10] = '{PNUM_SER_ADDR, PNUM_SER_ADDR, PNUM_SER_ADDR, PNUM_SER_BAUD, PNUM_SER_PROTO,
        PNUM_SER_PROTO, PNUM_SER_PROTO, PNUM_SER_PROTO, PNUM_ERR_ACTION, 10'h2ae};
    logic [15:0] td[10] = '{0, 248, 247, 5, 0, 4, 3, 5, 6, 0};
    logic te[10] = '{1, 1, 0, 1, 1, 1, 0, 0, 1, 1};
    dcb_host_model u_host (.clock_i(clock_i), .req_o(req), .we_o(we), .src_o(src), .pnum_o(pnum),
        .wdata_o(wdata), .ack_i(ack), .refused_i(refd), .rdata_i(rdata));
    dcb_bank u_dut (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .we_i(we), .src_i(src), .pnum_i(pnum),
        .wdata_i(wdata), .ack_o(ack), .refused_o(refd), .rdata_o(rdata), .dclink_ext_i(fl[0]),
        .energy_save_i(fl[1]), .output_frequency_reduction_i(fl[2]), .decel_ramp_i(fl[3]),
        .accel_ramp_i(fl[4]), .ramp_frozen_i(fl[5]), .setpoint_ok_i(fl[6]), .dclink_reg_i(fl[7]),
        .defaults_load_i(dl), .defaults_load_code_i(dlc), .ride_through_i(fl[8]), .flying_start_i(fl[9]),
        .dc_brake_i(fl[10]), .pwm_enabled_i(fl[11]), .fault_i(fault), .fieldbus_active_i(fba),
        .ref_from_network_i(net), .comm_error_i(cerr), .ramp_enable_o(ramp_en), .general_enable_o(gen_en),
        .run_forward_o(fwd), .jog_enable_o(jog), .remote_o(rem), .second_ramp_o(ramp2),
        .fault_reset_o(frst), .fault_raise_o(fraise), .comm_tripped_o(trip), .speed_ref_o(sref),
        .speed_ref_valid_o(valid), .serial_slave_address_o(addr), .serial_bit_rate_o(rate),
        .serial_parity_o(par), .serial_two_stop_o(two_stop), .serial_protocol_o(proto));
    // clock, and pulse counters for one-cycle outputs
    initial begin
        clock_i = 0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (frst === 1'b1) n_frst++;
        if (fraise === 1'b1) n_raise++;
    end
    task automatic chk(input logic [16:0] got, exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic acc(input dcb_src_e s, input dcb_pnum_t p, input logic w, input logic [15:0] d);
        u_host.access(s, p, w, d, a, r, q);
        chk(a, 1, "ack");
    endtask : acc
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : wait_cyc
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    // watchdog: tests need under 1000 cycles
    initial begin
        #100us;
        mismatches++;
        print_verdict();
    end
    initial begin
        rst_i = 1; fl = '0; dl = 0; dlc = '0; fault = 0; fba = 0; net = 0; cerr = 0;
        repeat (16) @(posedge clock_i);
        rst_i <= 0;
        acc(SRC_OTHER, PNUM_SER_ADDR, 0, 0); chk(q, 1, "addr reset");
        acc(SRC_OTHER, PNUM_SER_PROTO, 0, 0); chk(q, 2, "proto reset");
        $display("test reset values done");
        // status pattern and inverse, 50 Hz then 60 Hz defaults
        for (int i = 0; i < 2; i++) begin
            st = i ? 12'h5a3 : 12'ha5c;
            @(posedge clock_i);
            fl <= st; dl <= 1; dlc <= i ? DEF_LOAD_60HZ : DEF_LOAD_50HZ;
            @(posedge clock_i);
            dl <= 0;
            acc(SRC_FIELDBUS, PNUM_STATUS_TWO, 0, 0);
            chk(q, {st[11:8], i == 0, st[7:3], 1'b0, st[2:0], 2'b00}, "status");
        end
        acc(SRC_SERIAL, PNUM_STATUS_TWO, 1, 16'hffff); chk(r, 1, "status write");
        $display("test status word done");
        // control word owner, stored bits, commands
        acc(SRC_FIELDBUS, PNUM_CW_SERIAL, 1, 16'h003f); chk(r, 1, "foreign cw");
        foreach (td[k]) if (k < 2) begin
            acc(SRC_SERIAL, PNUM_CW_SERIAL, 1, k ? 16'h002a : 16'hff55); chk(r, 0, "cw write");
            acc(SRC_OTHER, PNUM_CW_SERIAL, 0, 0); chk(q, k ? 16'h002a : 16'h0015, "cw read");
            chk({ramp2, rem, jog, fwd, gen_en, ramp_en}, k ? 6'h2a : 6'h15, "cmds");
        end
        // fault reset only with a fault
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_i);
            fault <= (i == 0);
            n0 = n_frst;
            acc(SRC_SERIAL, PNUM_CW_SERIAL, 1, 16'h0080);
            wait_cyc(3);
            chk(n_frst - n0, i == 0, "fault reset");
        end
        $display("test control word done");
        // each error action; a fresh control word clears the trip
        for (int k = 0; k < 6; k++) begin
            acc(SRC_SERIAL, PNUM_CW_SERIAL, 1, 16'h003f);
            acc(SRC_OTHER, PNUM_ERR_ACTION, 1, 16'(k)); chk(r, 0, "action write");
            n0 = n_raise;
            @(posedge clock_i);
            cerr <= 1;
            @(posedge clock_i);
            cerr <= 0;
            wait_cyc(3);
            chk({trip, ramp_en, gen_en, rem}, {k != 0, k != 1, !(k == 2 || k == 3), !(k == 3 || k == 4)}, "react");
            chk(n_raise - n0, k == 5, "raise");
        end
        $display("test comm error done");
        // speed references: owner only, network gated, signed scale
        acc(SRC_FIELDBUS, PNUM_REF_SERIAL, 1, 16'h1234); chk(r, 1, "foreign ref");
        acc(SRC_SERIAL, PNUM_REF_SERIAL, 1, SPEED_RATED);
        acc(SRC_FIELDBUS, PNUM_REF_FBUS, 1, 16'he000); chk(r, 0, "fbus ref");
        acc(SRC_FIELDBUS, PNUM_CW_FBUS, 1, 16'h0013); chk(r, 0, "fbus cw");
        chk(sref, 0, "ref gated");
        @(posedge clock_i);
        net <= 1;
        wait_cyc(2);
        chk({valid, sref}, 17'h12000, "rated ref");
        @(posedge clock_i);
        fba <= 1;
        wait_cyc(2);
        chk({valid, sref}, 17'h1e000, "negative ref");
        chk({ramp2, rem, jog, fwd, gen_en, ramp_en}, 6'h13, "fbus cmds");
        $display("test speed reference done");
        // serial settings: ranges, rate codes, byte formats
        foreach (td[k]) begin
            acc(SRC_OTHER, tp[k], 1, td[k]); chk(r, te[k], "range");
        end
        chk({addr, proto}, {8'hf7, PROTO_MASTER}, "addr proto");
        for (int k = 0; k < 6; k++) begin
            acc(SRC_OTHER, PNUM_SER_FMT, 1, 16'(k));
            if (k < 5) acc(SRC_OTHER, PNUM_SER_BAUD, 1, 16'(k));
            wait_cyc(2);
            chk({par, two_stop}, {2'(k % 3), k >= 3}, "format");
            if (k < 5) chk(rate, 17'(rt[k]), "rate");
        end
        acc(SRC_OTHER, PNUM_SER_FMT, 1, 16'h0006); chk(r, 1, "format range");
        $display("test serial settings done");
        print_verdict();
    end
endmodule : drive_comm_control_status_bank_tb
